/* File: logic/clock_run_pkg.sv */
`default_nettype none
package clock_run_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_offset = 8'h3c;
  localparam logic [7:0] int_status_offset = 8'h40;
  localparam logic [7:0] int_mask_offset = 8'h44;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int status_bit = 15;
  localparam int enable_bit = 8;
  localparam int clkrun_mode_bit = 0;
  localparam int int_event_bit = 0;
  localparam int int_width = 1;
  // ----------------------------------------------------------------
  // Handshake timing, in PCI clock rising edges
  // ----------------------------------------------------------------
  localparam int hold_edges = 2;
  localparam int idle_edges = 2;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;
  typedef enum logic [1:0] {st_idle, st_wait_deasserted, st_assert, st_release} run_state_e;
endpackage : clock_run_pkg
`default_nettype wire

/* File: logic/clock_run_power_control.sv */
`default_nettype none
module clock_run_power_control
  import clock_run_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial configuration memory load of the enable bit
  input wire logic eeprom_load,
  input wire logic eeprom_enable,
  // Config-space mirror of status and enable
  input wire logic cfg_enable_write,
  input wire logic cfg_enable_value,
  input wire logic cfg_status_clear,
  output logic cfg_power_mgmt_enable,
  output logic cfg_power_mgmt_status,
  // Requests from the rest of the controller
  input wire logic traffic_pending,
  input wire logic rx_data_ready,
  input wire logic wake_on_network,
  input wire logic clock_stopped,
  // Shared open-drain pin
  input wire logic clock_run_request_n_in,
  output logic clock_run_request_n_out,
  output logic clock_run_request_n_oe,
  // Receive clock multiplexer select, one picks local reference clock
  output logic rx_clock_select_local,
  // Interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic power_event_status;
  logic power_event_enable;
  logic clkrun_mode;
  logic [int_width-1:0] int_status;
  logic [int_width-1:0] int_mask;
  run_state_e state;
  run_state_e next_state;
  logic [1:0] edge_count;
  logic [1:0] next_edge_count;
  logic pin_s1, pin_s2, pin_s3;
  logic pin_level;
  logic pme_request;
  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = aw_addr == ctrl_offset;
  wire wr_stat = aw_addr == int_status_offset;
  wire wr_mask = aw_addr == int_mask_offset;
  wire wr_hit = wr_ctrl || wr_stat || wr_mask;
  wire lane0 = w_strb[0];
  wire lane1 = w_strb[1];
  wire clear_status_sw = do_write && wr_ctrl && lane1 && w_data[status_bit];
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire rd_ctrl = s_axi_araddr == ctrl_offset;
  wire rd_stat = s_axi_araddr == int_status_offset;
  wire rd_mask = s_axi_araddr == int_mask_offset;
  wire rd_hit = rd_ctrl || rd_stat || rd_mask;
  wire [31:0] ctrl_view = {16'h0000, power_event_status, 6'h00, power_event_enable,
                           7'h00, clkrun_mode};
  wire [31:0] rd_value = rd_ctrl ? ctrl_view :
                         rd_stat ? {31'h0000_0000, int_status} :
                         rd_mask ? {31'h0000_0000, int_mask} : 32'h0000_0000;

  // Address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? axi_okay : axi_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready flops so the outputs stay registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= axi_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_hit ? axi_okay : axi_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register, mirrored with the config copy
  // ----------------------------------------------------------------
  // Latest writer wins; memory load sits last so power-on contents stick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_event_enable <= ctrl_reset[enable_bit];
      clkrun_mode <= ctrl_reset[clkrun_mode_bit];
    end else begin
      if (do_write && wr_ctrl && lane1)
        power_event_enable <= w_data[enable_bit];
      if (do_write && wr_ctrl && lane0)
        clkrun_mode <= w_data[clkrun_mode_bit];
      if (cfg_enable_write)
        power_event_enable <= cfg_enable_value;
      if (eeprom_load)
        power_event_enable <= eeprom_enable;
    end
  end

  // Sticky status: a new event beats a clear in the same cycle
  wire status_event = pme_request || state == st_assert;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      power_event_status <= ctrl_reset[status_bit];
    else if (status_event)
      power_event_status <= 1'b1;
    else if (clear_status_sw || cfg_status_clear)
      power_event_status <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin sampling and clock-run handshake
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= clock_run_request_n_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
        pin_level <= pin_s3;
    end
  end

  // With the enable clear nothing here holds the clock; software parks the receiver first
  // Clock need; a pending interrupt is deliberately not part of it
  wire need_clock = traffic_pending || (clock_stopped && (rx_data_ready || wake_on_network));
  wire may_drive = clkrun_mode && power_event_enable;
  assign pme_request = !clkrun_mode && wake_on_network;

  // Idle, wait for two high samples, assert two edges, release
  always_comb begin
    next_state = state;
    next_edge_count = edge_count;
    case (state)
      st_idle: begin
        next_edge_count = 2'd0;
        if (may_drive && need_clock)
          next_state = st_wait_deasserted;
      end
      st_wait_deasserted: begin
        if (!may_drive || !need_clock) begin
          next_state = st_idle;
          next_edge_count = 2'd0;
        end else if (!pin_level) begin
          next_edge_count = 2'd0;
        end else if (edge_count == 2'(idle_edges - 1)) begin
          next_state = st_assert;
          next_edge_count = 2'd0;
        end else begin
          next_edge_count = edge_count + 2'd1;
        end
      end
      st_assert: begin
        if (!may_drive) begin
          next_state = st_idle;
          next_edge_count = 2'd0;
        end else if (edge_count == 2'(hold_edges - 1)) begin
          next_state = st_release;
          next_edge_count = 2'd0;
        end else begin
          next_edge_count = edge_count + 2'd1;
        end
      end
      st_release: begin
        // The synced level lags our own drive, so a stale high must not end
        // this state: see the line low first, then wait for the resource to let go
        if (!pin_level)
          next_edge_count = 2'd1;
        if (edge_count != 2'd0 && pin_level) begin
          next_state = st_idle;
          next_edge_count = 2'd0;
        end
      end
      default: begin
        next_state = st_idle;
        next_edge_count = 2'd0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      edge_count <= 2'd0;
    end else begin
      state <= next_state;
      edge_count <= next_edge_count;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, receive clock select, interrupt
  // ----------------------------------------------------------------
  // Output level is always low; only the enable moves
  wire drive_clkrun = next_state == st_assert && may_drive;
  wire drive_pme = !clkrun_mode && power_event_enable && power_event_status;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_run_request_n_out <= 1'b0;
      clock_run_request_n_oe <= 1'b0;
    end else begin
      clock_run_request_n_out <= 1'b0;
      clock_run_request_n_oe <= power_event_enable && (drive_clkrun || drive_pme);
    end
  end

  // In clock-run mode a high line means clock stopped or slowing: run receiver on local clock
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rx_clock_select_local <= 1'b0;
    else
      rx_clock_select_local <= clkrun_mode && pin_level;
  end

  // Event interrupt, write one to clear, set beats clear
  wire int_event = state == st_assert && edge_count == 2'd0;
  wire mask_write = do_write && wr_mask && lane0;
  wire int_clear = do_write && wr_stat && lane0 && w_data[int_event_bit];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
      int_mask <= '0;
    end else begin
      if (mask_write)
        int_mask <= w_data[int_width-1:0];
      if (int_event)
        int_status[int_event_bit] <= 1'b1;
      else if (int_clear)
        int_status[int_event_bit] <= 1'b0;
    end
  end

  // Level interrupt from a flop so the line never glitches on a decode
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_mask);
  end

  // Config-space copy runs one cycle behind the local bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_power_mgmt_enable <= 1'b0;
      cfg_power_mgmt_status <= 1'b0;
    end else begin
      cfg_power_mgmt_enable <= power_event_enable;
      cfg_power_mgmt_status <= power_event_status;
    end
  end
endmodule : clock_run_power_control
`default_nettype wire

/* File: tb/clock_run_chk.sv */
`default_nettype none
module clock_run_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Mirror, pin and clock select
  input wire logic cfg_status_clear,
  input wire logic cfg_power_mgmt_enable,
  input wire logic cfg_power_mgmt_status,
  input wire logic clock_run_request_n_in,
  input wire logic clock_run_request_n_out,
  input wire logic clock_run_request_n_oe,
  input wire logic rx_clock_select_local
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------
  // Handshake steps
  // ----------------
  // Select high marks clock-run mode, so a level in event mode is not taken for a start
  sequence start_s;
    $rose(clock_run_request_n_oe) && rx_clock_select_local;
  endsequence
  sequence hold_s;
    clock_run_request_n_oe ##1 !clock_run_request_n_oe;
  endsequence
  pin_low_only_a: assert property (clock_run_request_n_oe |-> !clock_run_request_n_out)
    else $error("shared pin driven high");
  hold_two_a: assert property (start_s |=> hold_s)
    else $error("assertion not held two edges");
  idle_before_a: assert property (start_s |-> $past(clock_run_request_n_in, 1)
    && $past(clock_run_request_n_in, 2)) else $error("asserted without idle line");
  disabled_quiet_a: assert property (!cfg_power_mgmt_enable [*2] |-> !clock_run_request_n_oe)
    else $error("pin driven while disabled");
  line_low_pci_a: assert property (!clock_run_request_n_in [*6] |-> !rx_clock_select_local)
    else $error("local clock kept while line low");
  status_sticky_a: assert property ($fell(cfg_power_mgmt_status) |-> s_axi_bvalid
    || $past(s_axi_bvalid) || $past(cfg_status_clear) || $past(cfg_status_clear, 2))
    else $error("status lost without clear");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
endmodule : clock_run_chk
bind clock_run_power_control clock_run_chk i_chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .cfg_status_clear, .cfg_power_mgmt_enable, .cfg_power_mgmt_status,
  .clock_run_request_n_in, .clock_run_request_n_out, .clock_run_request_n_oe,
  .rx_clock_select_local
);
`default_nettype wire

/* File: tb/clock_resource_model.sv */
`default_nettype none
module clock_resource_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // System intent and device drive
  input wire logic stop_req,
  input wire logic device_oe,
  // Open-drain pull on the shared line
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold_cnt;
  // Take the line over once a device pulls it, then keep it low a while
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= 3'h0;
      pull_low <= 1'b0;
    end else if (device_oe && hold_cnt == 3'h0) begin
      hold_cnt <= 3'h5;
      pull_low <= 1'b1;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      pull_low <= !stop_req;
    end
  end
endmodule : clock_resource_model
`default_nettype wire

/* File: tb/pci_clock_run_power_event_tb_top.sv */
`default_nettype none
module pci_clock_run_power_event_tb_top
  import clock_run_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, stop_req;
  logic eeprom_load, eeprom_enable, cfg_enable_write, cfg_enable_value, cfg_status_clear;
  logic cfg_power_mgmt_enable, cfg_power_mgmt_status, traffic_pending, rx_data_ready;
  logic wake_on_network, clock_stopped, clock_run_request_n_in, clock_run_request_n_out;
  logic clock_run_request_n_oe, rx_clock_select_local, pull_low, sel;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp, bresp;
  int fails, n_tests, cyc, hi;
  clock_run_power_control i_dut (
    .aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .eeprom_load, .eeprom_enable,
    .cfg_enable_write, .cfg_enable_value, .cfg_status_clear,
    .cfg_power_mgmt_enable, .cfg_power_mgmt_status,
    .traffic_pending, .rx_data_ready, .wake_on_network, .clock_stopped,
    .clock_run_request_n_in, .clock_run_request_n_out, .clock_run_request_n_oe,
    .rx_clock_select_local, .irq
  );
  clock_resource_model i_sys (.aclk, .aresetn, .stop_req, .device_oe(clock_run_request_n_oe),
    .pull_low);
  // Pulled-up line, low while either party pulls
  assign clock_run_request_n_in = !(clock_run_request_n_oe || pull_low);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    {aw, w} = 2'b11;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    {rdat, rresp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  // Counts pin-drive cycles; the system stops asking once a device pulls
  task automatic watch();
    {hi, sel} = '0;
    repeat (30) begin
      @(negedge aclk);
      if (clock_run_request_n_oe === 1'b1) {hi, stop_req} = {hi + 1, 1'b0};
      sel |= rx_clock_select_local;
    end
  endtask : watch
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs();
    rd(ctrl_offset);
    chk("ctrl reset", ctrl_reset, rdat);
    wr(ctrl_offset, 32'hffff_ffff);
    rd(ctrl_offset);
    chk("ctrl fields", 32'h0000_0101, rdat);
    wr(8'h10, 32'h1);
    chk("bad write", {30'h0, axi_slverr}, {30'h0, bresp});
    rd(8'h10);
    chk("bad read resp", {30'h0, axi_slverr}, {30'h0, rresp});
    chk("bad read data", 32'h0, rdat);
    wr(ctrl_offset, 32'h0);
    $display("test regs over");
  endtask : t_regs
  task automatic t_load();
    {eeprom_enable, eeprom_load} <= 2'b11;
    @(posedge aclk);
    {eeprom_load, cfg_enable_write} <= 2'b01;
    @(posedge aclk);
    cfg_enable_write <= 1'b0;
    rd(ctrl_offset);
    chk("stored enable", 32'h0, rdat);
    chk("mirror", 32'h0, {31'h0, cfg_power_mgmt_enable});
    eeprom_load <= 1'b1;
    @(posedge aclk);
    eeprom_load <= 1'b0;
    rd(ctrl_offset);
    chk("loaded enable", 32'h100, rdat);
    $display("test load over");
  endtask : t_load
  task automatic t_event(input logic [2:0] need, input logic en);
    wr(int_mask_offset, 32'h1);
    wr(ctrl_offset, {23'h0, en, 8'h1});
    {traffic_pending, rx_data_ready, wake_on_network, clock_stopped} <= {need, !need[2]};
    stop_req <= 1'b1;
    watch();
    chk("drive cycles", en ? 32'd2 : 32'd0, 32'(hi));
    chk("local clock", 32'h1, {31'h0, sel});
    @(posedge aclk);
    {traffic_pending, rx_data_ready, wake_on_network, clock_stopped} <= '0;
    if (en) begin
      chk("event status", 32'h3, {30'h0, cfg_power_mgmt_status, irq});
      stop_req <= 1'b1;
      watch();
      chk("no hold off", 32'h0, 32'(hi));
      wr(int_mask_offset, 32'h0);
      repeat (2) @(negedge aclk);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(int_status_offset, 32'h1);
      wr(ctrl_offset, 32'h8000);
      repeat (2) @(negedge aclk);
      chk("cleared", 32'h0, {30'h0, cfg_power_mgmt_status, irq});
    end
    stop_req <= 1'b0;
    $display("test event %b over", need);
  endtask : t_event
  task automatic t_pme();
    wr(ctrl_offset, 32'h100);
    wake_on_network <= 1'b1;
    @(posedge aclk);
    wake_on_network <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("wake drive", 32'h1, {31'h0, clock_run_request_n_oe});
    @(posedge aclk);
    cfg_status_clear <= 1'b1;
    @(posedge aclk);
    cfg_status_clear <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("wake cleared", 32'h0, {30'h0, cfg_power_mgmt_status, clock_run_request_n_oe});
    $display("test wake over");
  endtask : t_pme
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {eeprom_load, eeprom_enable, cfg_enable_write, cfg_enable_value, cfg_status_clear} = '0;
    {traffic_pending, rx_data_ready, wake_on_network, clock_stopped, stop_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_load();
    for (int i = 0; i < 3; i++) t_event(3'b001 << i, 1'b1);
    // Enable clear: the physical layer counts as shut down before the clock stops
    t_event(3'b100, 1'b0);
    t_pme();
    summarize();
  end
endmodule : pci_clock_run_power_event_tb_top
`default_nettype wire
